/* dv/tccu_cnt_model.sv */
// Free-running counter model that feeds the capture and compare unit
`timescale 1ns/10ps
module tccu_cnt_model (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Bench control
	input wire logic stop_in,
	input wire logic hold_in,
	input wire logic load_in,
	input wire logic [15:0] load_val_in,
	// Counter link
	output logic [15:0] counter_out,
	output logic rollover_out
);
	logic [1:0] pre; // Divide-by-four prescaler
	// Count once per four clocks; stop freezes the count
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			counter_out <= 16'hfffc;
			pre <= 2'h0;
			rollover_out <= 1'b0;
		end else begin
			rollover_out <= 1'b0;
			if (load_in) begin
				counter_out <= load_val_in;
			end else if (!stop_in && !hold_in) begin
				pre <= pre + 2'h1;
				// Advance on the last cycle of the period
				if (pre == 2'h3) begin
					counter_out <= counter_out + 16'h0001;
					rollover_out <= (counter_out == 16'hffff);
				end
			end
		end
	end
endmodule : tccu_cnt_model

/* dv/tccu_top_tb.sv */
// Self-checking bench of the timer capture and compare unit
`timescale 1ns/10ps
`include "tccu_defines.svh"
module tccu_top_tb;
	// Capture case: control, pin start, pin end, capture expected
	typedef struct packed {
		logic [7:0] ctrl;
		logic from;
		logic to;
		logic hit;
	} tccu_row_t;
	localparam int PER = 4; // Clocks per counter step
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0, rd = 1'b0, clr = 1'b0, stop = 1'b0, pin = 1'b0;
	logic hold = 1'b1, load = 1'b0;
	logic [15:0] lval = 16'h0000;
	logic [7:0] rdat;
	wire logic [7:0] rdata;
	wire logic [15:0] counter;
	wire logic roll, cpin, irq;
	int n_errors = 0;
	int n_tests = 0;
	tccu_row_t rows [4] = '{'{8'h82, 1'b0, 1'b1, 1'b1}, '{8'h02, 1'b1, 1'b0, 1'b0},
		'{8'h00, 1'b1, 1'b0, 1'b1}, '{8'h80, 1'b0, 1'b1, 1'b0}};
	// Clock source
	always #2 mclk = ~mclk;
	tccu_top uut (.mclk_in(mclk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .counter_in(counter),
		.rollover_in(roll), .counter_low_read_in(clr), .stop_in(stop),
		.capture_input_pin_in(pin), .compare_output_pin_out(cpin), .timer_irq_out(irq));
	tccu_cnt_model model (.mclk_in(mclk), .rst_in(rst), .stop_in(stop), .hold_in(hold),
		.load_in(load), .load_val_in(lval), .counter_out(counter), .rollover_out(roll));
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// One-cycle write strobe
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic st_chk(input int b, input logic e);
		logic [7:0] s;
		rd_reg(`TCCU_A_STAT, s);
		chk(16'(s[b]), 16'(e));
	endtask : st_chk
	task automatic cap_chk(input logic [15:0] e);
		logic [7:0] h, l;
		rd_reg(`TCCU_A_CAPH, h);
		rd_reg(`TCCU_A_CAPL, l);
		chk({h, l}, e);
	endtask : cap_chk
	task automatic pin_to(input logic v);
		@(posedge mclk);
		pin <= v;
		tick(PER);
	endtask : pin_to
	// Preset the counter model and choose whether it runs
	task automatic set_cnt(input logic [15:0] v, input logic h);
		@(posedge mclk);
		lval <= v;
		load <= 1'b1;
		hold <= h;
		@(posedge mclk);
		load <= 1'b0;
	endtask : set_cnt
	task automatic pulse_clr();
		@(posedge mclk);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
	endtask : pulse_clr
	task automatic final_report();
		if (n_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report
	// Watchdog cuts a hang short
	initial begin
		#80000;
		n_errors++;
		final_report();
	end
	// Main sequence
	initial begin
		tick(5);
		rst <= 1'b0;
		rd_reg(`TCCU_A_CTRL, rdat);
		chk(16'(rdat), 16'h0000);
		chk(16'(cpin), 16'h0000);
		// Force one match so the unknown compare flag becomes set
		set_cnt(16'h0000, 1'b1);
		wr_reg(`TCCU_A_CMPH, 8'h00);
		wr_reg(`TCCU_A_CMPL, 8'h00);
		tick(2 * PER);
		set_cnt(16'h4321, 1'b1);
		// Initialise compare: inhibit, arm, write low to clear
		wr_reg(`TCCU_A_CMPH, 8'h00);
		rd_reg(`TCCU_A_STAT, rdat);
		wr_reg(`TCCU_A_CMPL, 8'h00);
		rd_reg(`TCCU_A_CAPL, rdat);
		pulse_clr();
		st_chk(6, 1'b0);
		// Edge select, capture value and flag per row
		foreach (rows[i]) begin
			wr_reg(`TCCU_A_CTRL, rows[i].ctrl);
			pin_to(rows[i].from);
			rd_reg(`TCCU_A_STAT, rdat);
			rd_reg(`TCCU_A_CAPL, rdat);
			pin_to(rows[i].to);
			chk(16'(irq), 16'(rows[i].hit & rows[i].ctrl[7]));
			st_chk(7, rows[i].hit);
			if (rows[i].hit) begin
				cap_chk(16'h4322);
			end
		end
		// Pending high read keeps the old capture
		wr_reg(`TCCU_A_CTRL, 8'h02);
		pin_to(1'b0);
		pin_to(1'b1);
		set_cnt(16'h5678, 1'b1);
		rd_reg(`TCCU_A_CAPH, rdat);
		pin_to(1'b0);
		pin_to(1'b1);
		rd_reg(`TCCU_A_CAPL, rdat);
		chk(16'(rdat), 16'h0022);
		pin_to(1'b0);
		pin_to(1'b1);
		cap_chk(16'h5679);
		// Compare: inhibit, match, level, clear
		set_cnt(16'h1234, 1'b1);
		wr_reg(`TCCU_A_CTRL, 8'h41);
		wr_reg(`TCCU_A_CMPL, 8'h34);
		wr_reg(`TCCU_A_CMPH, 8'h12);
		tick(3 * PER);
		st_chk(6, 1'b0);
		wr_reg(`TCCU_A_CMPL, 8'h34);
		tick(2 * PER);
		chk(16'(cpin), 16'h0001);
		chk(16'(irq), 16'h0001);
		st_chk(6, 1'b1);
		wr_reg(`TCCU_A_CTRL, 8'h40);
		tick(2 * PER);
		chk(16'(cpin), 16'h0000);
		wr_reg(`TCCU_A_CMPH, 8'h12);
		rd_reg(`TCCU_A_STAT, rdat);
		wr_reg(`TCCU_A_CMPL, 8'h35);
		tick(2 * PER);
		chk(16'(irq), 16'h0000);
		st_chk(6, 1'b0);
		// Edge during stop shows only after wake
		wr_reg(`TCCU_A_CTRL, 8'h82);
		rd_reg(`TCCU_A_STAT, rdat);
		rd_reg(`TCCU_A_CAPL, rdat);
		@(posedge mclk);
		stop <= 1'b1;
		pin_to(1'b0);
		pin_to(1'b1);
		chk(16'(irq), 16'h0000);
		@(posedge mclk);
		stop <= 1'b0;
		tick(PER);
		chk(16'(irq), 16'h0001);
		cap_chk(16'h1235);
		// Rollover flag and its clearing pair
		wr_reg(`TCCU_A_CTRL, 8'h20);
		set_cnt(16'hfff8, 1'b0);
		tick(10 * PER);
		chk(16'(irq), 16'h0001);
		st_chk(5, 1'b1);
		tick(PER);
		st_chk(5, 1'b1);
		pulse_clr();
		st_chk(5, 1'b0);
		// Reset in mid-run keeps data registers
		wr_reg(`TCCU_A_CTRL, 8'h41);
		set_cnt(16'h1235, 1'b1);
		tick(2 * PER);
		chk(16'(cpin), 16'h0001);
		@(posedge mclk);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		rd_reg(`TCCU_A_CTRL, rdat);
		chk(16'(rdat), 16'h0000);
		chk(16'(cpin), 16'h0000);
		rd_reg(`TCCU_A_CMPL, rdat);
		chk(16'(rdat), 16'h0035);
		cap_chk(16'h1235);
		st_chk(7, 1'b1);
		// Unmapped places read as zero
		wr_reg(3'h7, 8'hff);
		rd_reg(3'h7, rdat);
		chk(16'(rdat), 16'h0000);
		rd_reg(`TCCU_A_CMPL, rdat);
		chk(16'(rdat), 16'h0035);
		final_report();
	end
endmodule : tccu_top_tb

/* rtl/tccu_defines.svh */
// Constants of the timer capture and compare unit
//
// Summary of operation
// - Compare runs once per four cycles, at T01
// - Match sets compare flag at T11, loads level
// - High compare write blocks compares until low write
// - Output latch loads only on valid match
// - Compare bytes and flag survive reset
// - Compare interrupt follows flag when enabled
// - Status read then low write clears compare
// - Edge select bit picks capture edge
// - Captured value is counter plus one
// - Every qualifying live edge overwrites capture bytes unless a high read is pending or a held stop edge is shown in the same cycle
// - High capture read blocks transfers until low read
// - Capture flag sets on edge, clears by read pair
// - Rollover flag sets on wrap, clears by read pair
// - Alternate counter reads never clear rollover
// - Compare pin low after reset until match
// - Only control register and control state are reset; capture retained
// - Level bit holds next compare output level
// - Timer runs in wait, interrupt wakes
// - Stop freezes timer logic until exit
// - Stop edge arms capture, shown on wake
`ifndef TCCU_DEFINES_SVH
`define TCCU_DEFINES_SVH
// Register indices on the local port
`define TCCU_A_CTRL 3'h0
`define TCCU_A_STAT 3'h1
`define TCCU_A_CAPH 3'h2
`define TCCU_A_CAPL 3'h3
`define TCCU_A_CMPH 3'h4
`define TCCU_A_CMPL 3'h5
// Control bit positions
`define TCCU_B_CAP_IE 7
`define TCCU_B_CMP_IE 6
`define TCCU_B_ROL_IE 5
`define TCCU_B_EDGE 1
`define TCCU_B_LVL 0
// Flag vector positions
`define TCCU_F_CAP 2
`define TCCU_F_CMP 1
`define TCCU_F_ROL 0
// Reset and arithmetic constants
`define TCCU_CTRL_RST 8'h00
`define TCCU_RD_IDLE 8'h00
`define TCCU_STAT_PAD 5'h00
`define TCCU_ONE 16'h0001
`endif

/* rtl/tccu_pkg.sv */
// Types of the timer capture and compare unit
package tccu_pkg;
	// Timer state within one counter period, one-hot
	typedef enum logic [3:0] {
		TCCU_T00 = 4'h1,
		TCCU_T01 = 4'h2,
		TCCU_T10 = 4'h4,
		TCCU_T11 = 4'h8
	} tccu_phase_t;
	// State that reset clears
	typedef struct packed {
		logic [7:0] ctrl;
		tccu_phase_t phase;
		logic cmp_inh;
		logic cap_inh;
		logic match;
		logic [2:0] arm;
		logic cap_prev;
		logic stop_pend;
		logic stop_prev;
		logic out_pin;
		logic [7:0] rdata;
	} tccu_ctl_t;
	// State that reset leaves alone
	typedef struct packed {
		logic [15:0] cmp;
		logic [15:0] cap;
		logic [15:0] pend_val;
		logic [2:0] flags;
	} tccu_dat_t;
endpackage : tccu_pkg

/* rtl/tccu_top.sv */
// Timer capture and compare unit: registers, match, capture, flags
`timescale 1ns/10ps
`include "tccu_defines.svh"

module tccu_top (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic rst_in,
	// Register port
	input wire logic [2:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// Free-running counter link
	input wire logic [15:0] counter_in,
	input wire logic rollover_in,
	input wire logic counter_low_read_in,
	// Power mode
	input wire logic stop_in,
	// Pins
	input wire logic capture_input_pin_in,
	output logic compare_output_pin_out,
	// Interrupt to the processor
	output logic timer_irq_out
);

	// Register-port access decode, used for every side effect
	function automatic logic hit(input logic strobe, input logic [2:0] a,
		input logic [2:0] target);
		hit = strobe && (a == target);
	endfunction : hit

	// Registered state, split by reset behaviour
	tccu_pkg::tccu_ctl_t st;
	tccu_pkg::tccu_ctl_t next_st;
	tccu_pkg::tccu_dat_t d;
	tccu_pkg::tccu_dat_t next_d;

	// Decoded strobes
	logic wr_ctrl;
	logic wr_cmph;
	logic wr_cmpl;
	logic rd_stat;
	logic rd_caph;
	logic rd_capl;
	// Selected capture edge seen this cycle
	logic cap_edge;
	// Counter value plus one, as captured
	logic [15:0] cap_val;
	// Stop mode just ended
	logic stop_exit;

	// Strobe decode
	assign wr_ctrl = hit(wr_in, addr_in, `TCCU_A_CTRL);
	assign wr_cmph = hit(wr_in, addr_in, `TCCU_A_CMPH);
	assign wr_cmpl = hit(wr_in, addr_in, `TCCU_A_CMPL);
	assign rd_stat = hit(rd_in, addr_in, `TCCU_A_STAT);
	assign rd_caph = hit(rd_in, addr_in, `TCCU_A_CAPH);
	assign rd_capl = hit(rd_in, addr_in, `TCCU_A_CAPL);

	// Edge detect: level changed and now equals the select bit
	assign cap_edge = (capture_input_pin_in != st.cap_prev) &&
		(capture_input_pin_in == st.ctrl[`TCCU_B_EDGE]);
	// Synchronisation delay shows as one count more
	assign cap_val = counter_in + `TCCU_ONE;
	assign stop_exit = st.stop_prev && !stop_in;

	// Outputs straight from flip-flops or flags
	assign rdata_out = st.rdata;
	assign compare_output_pin_out = st.out_pin;
	// Any flag with its enable raises the request; also wakes from wait
	assign timer_irq_out = |(d.flags & st.ctrl[`TCCU_B_CAP_IE:`TCCU_B_ROL_IE]);

	// Next-state logic
	always_comb begin
		next_st = st;
		next_d = d;
		next_st.cap_prev = capture_input_pin_in;
		next_st.stop_prev = stop_in;

		// Control register writes
		if (wr_ctrl) begin
			next_st.ctrl = wdata_in;
		end
		// Compare bytes: high write inhibits matching, low write releases it
		if (wr_cmph) begin
			next_d.cmp[15:8] = wdata_in;
			next_st.cmp_inh = 1'b1;
		end
		if (wr_cmpl) begin
			next_d.cmp[7:0] = wdata_in;
			next_st.cmp_inh = 1'b0;
		end

		// High capture read freezes transfers until the low read
		if (rd_caph) begin
			next_st.cap_inh = 1'b1;
		end
		if (rd_capl) begin
			next_st.cap_inh = 1'b0;
		end

		// Clearing: status read arms each set flag, partner access clears
		if (wr_cmpl && st.arm[`TCCU_F_CMP]) begin
			next_d.flags[`TCCU_F_CMP] = 1'b0;
			next_st.arm[`TCCU_F_CMP] = 1'b0;
		end
		if (rd_capl && st.arm[`TCCU_F_CAP]) begin
			next_d.flags[`TCCU_F_CAP] = 1'b0;
			next_st.arm[`TCCU_F_CAP] = 1'b0;
		end
		// Only the primary low-byte strobe reaches here
		if (counter_low_read_in && st.arm[`TCCU_F_ROL]) begin
			next_d.flags[`TCCU_F_ROL] = 1'b0;
			next_st.arm[`TCCU_F_ROL] = 1'b0;
		end
		if (rd_stat) begin
			next_st.arm = d.flags;
		end

		// Read data, valid the cycle after the strobe
		next_st.rdata = `TCCU_RD_IDLE;
		if (rd_in) begin
			unique case (addr_in)
				`TCCU_A_CTRL: next_st.rdata = st.ctrl;
				`TCCU_A_STAT: next_st.rdata = {d.flags, `TCCU_STAT_PAD};
				`TCCU_A_CAPH: next_st.rdata = d.cap[15:8];
				`TCCU_A_CAPL: next_st.rdata = d.cap[7:0];
				`TCCU_A_CMPH: next_st.rdata = d.cmp[15:8];
				`TCCU_A_CMPL: next_st.rdata = d.cmp[7:0];
				// Unmapped indices read as zero
				default: next_st.rdata = `TCCU_RD_IDLE;
			endcase
		end

		if (stop_in) begin
			// Timer clock stopped: phase and compare frozen
			// First edge is held back, no flag, no wake
			if (cap_edge && !st.stop_pend) begin
				next_st.stop_pend = 1'b1;
				next_d.pend_val = cap_val;
			end
		end else begin
			// Timer state walks T00 T01 T10 T11
			unique case (st.phase)
				tccu_pkg::TCCU_T00: next_st.phase = tccu_pkg::TCCU_T01;
				tccu_pkg::TCCU_T01: next_st.phase = tccu_pkg::TCCU_T10;
				tccu_pkg::TCCU_T10: next_st.phase = tccu_pkg::TCCU_T11;
				tccu_pkg::TCCU_T11: next_st.phase = tccu_pkg::TCCU_T00;
				// Recover from a corrupted code
				default: next_st.phase = tccu_pkg::TCCU_T00;
			endcase
			// Compare once per period, at T01
			if (st.phase == tccu_pkg::TCCU_T01) begin
				next_st.match = !st.cmp_inh && (counter_in == d.cmp);
			end
			// Match takes effect at T11, flag set or not
			if (st.phase == tccu_pkg::TCCU_T11 && st.match) begin
				next_d.flags[`TCCU_F_CMP] = 1'b1;
				next_st.out_pin = st.ctrl[`TCCU_B_LVL];
				next_st.match = 1'b0;
			end
			// Counter wrap from the counter block
			if (rollover_in) begin
				next_d.flags[`TCCU_F_ROL] = 1'b1;
			end
			// Live capture overwrites regardless of flag
			if (cap_edge && !st.cap_inh) begin
				next_d.cap = cap_val;
			end
			if (cap_edge) begin
				next_d.flags[`TCCU_F_CAP] = 1'b1;
			end
			// Edge held over stop appears on wake
			if (stop_exit && st.stop_pend) begin
				next_st.stop_pend = 1'b0;
				next_d.flags[`TCCU_F_CAP] = 1'b1;
				if (!st.cap_inh) begin
					next_d.cap = d.pend_val;
				end
			end
		end
	end

	// Control state: cleared by reset, discarding a held stop edge
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			st.ctrl <= `TCCU_CTRL_RST;
			st.phase <= tccu_pkg::TCCU_T00;
			st.cmp_inh <= 1'b0;
			st.cap_inh <= 1'b0;
			st.match <= 1'b0;
			st.arm <= 3'h0;
			st.cap_prev <= 1'b0;
			st.stop_pend <= 1'b0;
			st.stop_prev <= 1'b0;
			st.out_pin <= 1'b0;
			st.rdata <= `TCCU_RD_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Data state: compare, capture and flags keep their value over reset
	always_ff @(posedge mclk_in) begin
		d <= next_d;
	end

	// Checks

	// Match at T01 raises the compare flag two cycles later
	property p_match_flag;
		@(posedge mclk_in) disable iff (rst_in)
		(st.phase == tccu_pkg::TCCU_T11 && st.match && !stop_in)
			|=> d.flags[`TCCU_F_CMP];
	endproperty
	a_match_flag: assert property (p_match_flag)
		else $error("compare flag not set after match");

	// Compare period is four cycles
	property p_period;
		@(posedge mclk_in) disable iff (rst_in)
		(st.phase == tccu_pkg::TCCU_T01 && !stop_in) ##1 (!stop_in)[*3]
			|=> st.phase == tccu_pkg::TCCU_T01;
	endproperty
	a_period: assert property (p_period)
		else $error("compare phase not four cycles apart");

	// High compare write holds off matching until low write
	property p_inhibit;
		@(posedge mclk_in) disable iff (rst_in)
		(st.cmp_inh && st.phase == tccu_pkg::TCCU_T01 && !stop_in) |=> !st.match;
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("compare ran while inhibited");

	// Pin changes only at T11 with a match pending
	property p_pin_cause;
		@(posedge mclk_in) disable iff (rst_in)
		$changed(compare_output_pin_out)
			|-> $past(st.match && st.phase == tccu_pkg::TCCU_T11);
	endproperty
	a_pin_cause: assert property (p_pin_cause)
		else $error("compare pin changed without match");

	// Enabled compare flag raises the request at once
	property p_cmp_irq;
		@(posedge mclk_in) disable iff (rst_in)
		($rose(d.flags[`TCCU_F_CMP]) && st.ctrl[`TCCU_B_CMP_IE]) |-> timer_irq_out;
	endproperty
	a_cmp_irq: assert property (p_cmp_irq)
		else $error("compare interrupt missing");

	// Compare flag falls only through the armed low write
	property p_cmp_clear;
		@(posedge mclk_in) disable iff (rst_in)
		$fell(d.flags[`TCCU_F_CMP]) |-> $past(wr_cmpl && st.arm[`TCCU_F_CMP]);
	endproperty
	a_cmp_clear: assert property (p_cmp_clear)
		else $error("compare flag cleared without sequence");

	// Captured value is counter plus one
	property p_cap_val;
		@(posedge mclk_in) disable iff (rst_in)
		(cap_edge && !stop_in && !st.cap_inh && !stop_exit)
			|=> d.cap == $past(counter_in) + `TCCU_ONE;
	endproperty
	a_cap_val: assert property (p_cap_val)
		else $error("capture value wrong");

	// Capture bytes frozen while the high byte read is pending
	property p_cap_hold;
		@(posedge mclk_in) disable iff (rst_in)
		(st.cap_inh && !rd_capl) |=> $stable(d.cap);
	endproperty
	a_cap_hold: assert property (p_cap_hold)
		else $error("capture changed while inhibited");

	// Rollover flag falls only through the primary low read
	property p_rol_clear;
		@(posedge mclk_in) disable iff (rst_in)
		$fell(d.flags[`TCCU_F_ROL])
			|-> $past(counter_low_read_in && st.arm[`TCCU_F_ROL]);
	endproperty
	a_rol_clear: assert property (p_rol_clear)
		else $error("rollover flag cleared without sequence");

	// Capture flag does not rise and phase holds while stopped
	property p_stop_quiet;
		@(posedge mclk_in) disable iff (rst_in)
		(stop_in && $past(stop_in)) |-> !$rose(d.flags[`TCCU_F_CAP]) && $stable(st.phase);
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("timer active during stop");

	// Selected live edge raises the capture flag
	property p_cap_flag;
		@(posedge mclk_in) disable iff (rst_in)
		(cap_edge && !stop_in) |=> d.flags[`TCCU_F_CAP];
	endproperty
	a_cap_flag: assert property (p_cap_flag)
		else $error("capture flag not set after edge");

	// Capture flag falls only through the armed low read
	property p_cap_clear;
		@(posedge mclk_in) disable iff (rst_in)
		$fell(d.flags[`TCCU_F_CAP]) |-> $past(rd_capl && st.arm[`TCCU_F_CAP]);
	endproperty
	a_cap_clear: assert property (p_cap_clear)
		else $error("capture flag cleared without sequence");

	// Enabled capture flag raises the request at once
	property p_cap_irq;
		@(posedge mclk_in) disable iff (rst_in)
		($rose(d.flags[`TCCU_F_CAP]) && st.ctrl[`TCCU_B_CAP_IE]) |-> timer_irq_out;
	endproperty
	a_cap_irq: assert property (p_cap_irq)
		else $error("capture interrupt missing");

	// Counter wrap raises the rollover flag
	property p_rol_set;
		@(posedge mclk_in) disable iff (rst_in)
		(rollover_in && !stop_in) |=> d.flags[`TCCU_F_ROL];
	endproperty
	a_rol_set: assert property (p_rol_set)
		else $error("rollover flag not set after wrap");

	// Edge held over stop raises the capture flag on wake
	property p_stop_wake;
		@(posedge mclk_in) disable iff (rst_in)
		(stop_exit && st.stop_pend) |=> d.flags[`TCCU_F_CAP];
	endproperty
	a_stop_wake: assert property (p_stop_wake)
		else $error("held capture not shown after wake");

	// Scenarios worth seeing
	c_match: cover property (@(posedge mclk_in) disable iff (rst_in)
		$rose(d.flags[`TCCU_F_CMP]));
	c_capture: cover property (@(posedge mclk_in) disable iff (rst_in)
		cap_edge && !stop_in);
	c_stop_wake: cover property (@(posedge mclk_in) disable iff (rst_in)
		stop_exit && st.stop_pend);
	c_rol_clear: cover property (@(posedge mclk_in) disable iff (rst_in)
		$fell(d.flags[`TCCU_F_ROL]));

endmodule : tccu_top
